// file: src/rtcu_pkg.sv
// package for the rotate-through-carry unit: widths, opcodes, phases
package rtcu_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam logic [5:0] OPC_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

    // one instruction cycle is four phases
    typedef enum logic [1:0] {
        RTCU_Q1 = 2'b00,
        RTCU_Q2 = 2'b01,
        RTCU_Q3 = 2'b10,
        RTCU_Q4 = 2'b11
    } rtcu_phase_t;

    typedef enum logic [1:0] {
        RTCU_OP_NONE = 2'b00,
        RTCU_OP_LEFT = 2'b01,
        RTCU_OP_RIGHT = 2'b10
    } rtcu_op_t;

    // file register write port
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rtcu_fwr_t;

    // whole module state
    typedef struct packed {
        logic [1:0] rst_sync;
        rtcu_phase_t phase;
        rtcu_op_t op;
        logic dest;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] operand;
        logic [DATA_W-1:0] result;
        logic carry_new;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic fre;
        rtcu_fwr_t fwr;
    } rtcu_state_t;
endpackage

// file: src/rtcu_core.sv
// rotate-through-carry datapath slice, four phases per instruction cycle
`timescale 1ns/1ps
module rtcu_core
    import rtcu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic [INSN_W-1:0] insn_in,
    input wire logic [DATA_W-1:0] freg_rdata_in,
    input wire logic acc_load_in,
    input wire logic [DATA_W-1:0] acc_load_data_in,
    input wire logic carry_load_in,
    input wire logic carry_load_data_in,
    output logic [ADDR_W-1:0] freg_addr_out,
    output logic freg_re_out,
    output logic freg_we_out,
    output logic [DATA_W-1:0] freg_wdata_out,
    output logic [DATA_W-1:0] acc_out,
    output logic carry_out,
    output logic zero_we_out,
    output logic dcarry_we_out,
    output logic [1:0] phase_out,
    output logic busy_out
);
    rtcu_state_t state_reg;
    rtcu_state_t state_next;
    logic rst_n;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // classify the opcode field of an instruction word
    function automatic rtcu_op_t decode_op(input logic [INSN_W-1:0] w);
        if (w[OPC_HI:OPC_LO] == OPC_ROT_LEFT) begin
            decode_op = RTCU_OP_LEFT;
        end else if (w[OPC_HI:OPC_LO] == OPC_ROT_RIGHT) begin
            decode_op = RTCU_OP_RIGHT;
        end else begin
            decode_op = RTCU_OP_NONE;
        end
    endfunction

    // rotate one place through carry; result in low byte, carry on top
    function automatic logic [DATA_W:0] rotate(input rtcu_op_t op,
            input logic [DATA_W-1:0] v, input logic c);
        if (op == RTCU_OP_LEFT) begin
            rotate = {v[MSB], v[MSB-1:0], c};
        end else begin
            rotate = {v[LSB], c, v[MSB:1]};
        end
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // release is synchronised so all state leaves reset on one edge
    assign rst_n = state_reg.rst_sync[1];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W:0] rot;
        rot = '0;
        state_next = state_reg;
        state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
        state_next.fre = 1'b0;
        state_next.fwr.we = 1'b0;
        if (!rst_n) begin
            state_next.phase = RTCU_Q1;
            state_next.op = RTCU_OP_NONE;
        end else begin
            // external loads of accumulator and carry from the rest of core
            if (acc_load_in) begin
                state_next.acc = acc_load_data_in;
            end
            if (carry_load_in) begin
                state_next.carry = carry_load_data_in;
            end
            case (state_reg.phase)
                RTCU_Q1: begin
                    state_next.op = decode_op(insn_in);
                    state_next.dest = insn_in[DEST_BIT];
                    state_next.addr = insn_in[ADDR_W-1:0];
                    state_next.phase = RTCU_Q2;
                end
                RTCU_Q2: begin
                    // read phase: strobe request, sample data
                    state_next.operand = freg_rdata_in;
                    state_next.phase = RTCU_Q3;
                end
                RTCU_Q3: begin
                    rot = rotate(state_reg.op, state_reg.operand,
                        state_reg.carry);
                    state_next.result = rot[DATA_W-1:0];
                    state_next.carry_new = rot[DATA_W];
                    state_next.phase = RTCU_Q4;
                    if (state_reg.op != RTCU_OP_NONE && state_reg.dest) begin
                        // write request registered to show in Q4
                        state_next.fwr.we = 1'b1;
                        state_next.fwr.addr = state_reg.addr;
                        state_next.fwr.data = rot[DATA_W-1:0];
                    end
                end
                RTCU_Q4: begin
                    // write phase; the rotate outranks an external load
                    if (state_reg.op != RTCU_OP_NONE) begin
                        state_next.carry = state_reg.carry_new;
                        if (!state_reg.dest) begin
                            state_next.acc = state_reg.result;
                        end
                    end
                    state_next.phase = RTCU_Q1;
                end
                default: begin
                    state_next.phase = RTCU_Q1;
                end
            endcase
            if (state_next.phase == RTCU_Q2 &&
                    state_next.op != RTCU_OP_NONE) begin
                state_next.fre = 1'b1; // read strobe during Q2
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clock enable low freezes every bit, phase counter included
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= '{rst_sync: 2'b00, phase: RTCU_Q1,
                op: RTCU_OP_NONE, dest: 1'b0, addr: ADDR_RST,
                operand: DATA_RST, result: DATA_RST, carry_new: 1'b0,
                acc: DATA_RST, carry: 1'b0, fre: 1'b0,
                fwr: '{we: 1'b0, addr: ADDR_RST, data: DATA_RST}};
        end else if (clk_en_in) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign freg_addr_out = state_reg.fwr.we ? state_reg.fwr.addr
        : state_reg.addr;
    assign freg_re_out = state_reg.fre;
    assign freg_we_out = state_reg.fwr.we;
    assign freg_wdata_out = state_reg.fwr.data;
    assign acc_out = state_reg.acc;
    assign carry_out = state_reg.carry;
    // rotates never touch zero or digit-carry
    assign zero_we_out = 1'b0;
    assign dcarry_we_out = 1'b0;
    assign phase_out = state_reg.phase;
    assign busy_out = state_reg.op != RTCU_OP_NONE;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // all checks share the core clock and the synchronised reset
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    // phase sequencing and decode; the release edge still holds Q1
    phase_walk_a: assert property (
        clk_en_in && phase_out == RTCU_Q4 |=> phase_out == RTCU_Q1)
        else $error("phase did not wrap");
    left_decode_a: assert property (
        clk_en_in && rst_n && phase_out == RTCU_Q1
        && insn_in[OPC_HI:OPC_LO] == OPC_ROT_LEFT
        |=> state_reg.op == RTCU_OP_LEFT)
        else $error("left rotate not decoded");
    right_decode_a: assert property (
        clk_en_in && rst_n && phase_out == RTCU_Q1
        && insn_in[OPC_HI:OPC_LO] == OPC_ROT_RIGHT
        |=> state_reg.op == RTCU_OP_RIGHT)
        else $error("right rotate not decoded");
    // rotate arithmetic, with the carry as it stood in Q3
    left_result_a: assert property (
        clk_en_in && phase_out == RTCU_Q3 && state_reg.op == RTCU_OP_LEFT
        |=> state_reg.result == {$past(state_reg.operand[MSB-1:0]),
            $past(carry_out)} && state_reg.carry_new ==
            $past(state_reg.operand[MSB]))
        else $error("left rotate result wrong");
    right_result_a: assert property (
        clk_en_in && phase_out == RTCU_Q3 && state_reg.op == RTCU_OP_RIGHT
        |=> state_reg.result == {$past(carry_out),
            $past(state_reg.operand[MSB:1])} && state_reg.carry_new ==
            $past(state_reg.operand[LSB]))
        else $error("right rotate result wrong");
    // Q4 write-back to the chosen destination
    acc_dest_a: assert property (
        clk_en_in && phase_out == RTCU_Q4 && busy_out && !state_reg.dest
        |=> acc_out == $past(state_reg.result) && !freg_we_out)
        else $error("accumulator not written");
    carry_write_a: assert property (
        clk_en_in && phase_out == RTCU_Q4 && busy_out
        |=> carry_out == $past(state_reg.carry_new))
        else $error("carry not written in Q4");
    freg_dest_a: assert property (
        freg_we_out |-> phase_out == RTCU_Q4
        && state_reg.dest && freg_wdata_out == state_reg.result)
        else $error("file write out of place");
    none_quiet_a: assert property (
        clk_en_in && phase_out == RTCU_Q4 && !busy_out
        && !acc_load_in && !carry_load_in
        |=> $stable(acc_out) && $stable(carry_out))
        else $error("non-rotate word changed acc or carry");
    read_phase_a: assert property (
        freg_re_out |-> phase_out == RTCU_Q2)
        else $error("read outside Q2");
    read_busy_a: assert property (
        freg_re_out |-> busy_out && freg_addr_out == state_reg.addr)
        else $error("read strobe without a rotate");
    // constant by design, kept so a later edit cannot slip a write in
    flags_kept_a: assert property (
        !zero_we_out && !dcarry_we_out)
        else $error("zero or digit carry touched");

    // main scenarios: both rotates, both destinations, stall, load race
    left_cov_c: cover property (phase_out == RTCU_Q4
        && state_reg.op == RTCU_OP_LEFT && !state_reg.dest);
    right_cov_c: cover property (phase_out == RTCU_Q4
        && state_reg.op == RTCU_OP_RIGHT && state_reg.dest);
    stall_cov_c: cover property (busy_out && !clk_en_in);
    load_cov_c: cover property (busy_out && acc_load_in && carry_load_in);
endmodule

// file: verif/test_rotate_through_carry_unit.sv
// self-checking bench for the rotate-through-carry unit
`timescale 1ns/1ps
module test_rotate_through_carry_unit;
    import rtcu_pkg::*;
    typedef struct packed {
        logic rot;
        logic d;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] acc;
        logic carry;
    } rtcu_note_t;
    logic clk_sys_in, arst_n_in, clk_en_in, acc_load_in, carry_load_in;
    logic carry_load_data_in;
    logic [INSN_W-1:0] insn_in;
    logic [DATA_W-1:0] freg_rdata_in, acc_load_data_in;
    logic [DATA_W-1:0] acc_out, freg_wdata_out;
    logic [ADDR_W-1:0] freg_addr_out;
    logic freg_re_out, freg_we_out, carry_out, zero_we_out, dcarry_we_out;
    logic [1:0] phase_out;
    logic busy_out, m_carry;
    logic cur_v = 1'b0;
    logic [DATA_W-1:0] m_acc;
    logic [31:0] seed;
    rtcu_note_t notes[$];
    rtcu_note_t cur = '0;
    int err_count, cmp_count, cyc;

    rtcu_core rtcu_core_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in), .insn_in(insn_in),
        .freg_rdata_in(freg_rdata_in), .acc_load_in(acc_load_in),
        .acc_load_data_in(acc_load_data_in), .carry_load_in(carry_load_in),
        .carry_load_data_in(carry_load_data_in),
        .freg_addr_out(freg_addr_out), .freg_re_out(freg_re_out),
        .freg_we_out(freg_we_out), .freg_wdata_out(freg_wdata_out),
        .acc_out(acc_out), .carry_out(carry_out), .zero_we_out(zero_we_out),
        .dcarry_we_out(dcarry_we_out), .phase_out(phase_out),
        .busy_out(busy_out));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic chk8(input string what, input logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk1(input string what, input logic e, input logic g);
        chk8(what, {7'h00, e}, {7'h00, g});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // bounded wait, sampled mid-cycle; a phase that never comes is an error
    task automatic wait_phase(input logic [1:0] p);
        for (int k = 0; k < 20; k++) begin
            @(negedge clk_sys_in);
            if (phase_out === p) break;
        end
        chk8("phase", {6'h00, p}, {6'h00, phase_out});
    endtask

    // present a word as the previous one enters Q3; optional load at Q2
    task automatic run(input logic [INSN_W-1:0] w, logic [7:0] rd, logic ld);
        rtcu_note_t n;
        logic [5:0] opc;
        logic [7:0] la;
        logic st;
        la = seed[7:0];
        st = seed[9];
        seed = lfsr_next(seed);
        @(posedge clk_sys_in);
        insn_in <= w;
        freg_rdata_in <= rd;
        acc_load_in <= 1'b0;
        carry_load_in <= 1'b0;
        // random one-cycle stall lands in Q3 of the word in flight
        clk_en_in <= !st;
        if (ld) begin
            m_acc = la;
            m_carry = la[0];
        end
        opc = w[OPC_HI:OPC_LO];
        n = '0;
        n.d = w[DEST_BIT];
        n.addr = w[ADDR_W-1:0];
        n.rot = (opc == OPC_ROT_LEFT) || (opc == OPC_ROT_RIGHT);
        if (opc == OPC_ROT_LEFT) begin
            n.wdata = {rd[6:0], m_carry};
            m_carry = rd[7];
        end else if (opc == OPC_ROT_RIGHT) begin
            n.wdata = {m_carry, rd[7:1]};
            m_carry = rd[0];
        end
        if (n.rot && !n.d) m_acc = n.wdata;
        n.acc = m_acc;
        n.carry = m_carry;
        notes.push_back(n);
        @(posedge clk_sys_in);
        clk_en_in <= 1'b1;
        wait_phase(2'h0);
        @(posedge clk_sys_in);
        acc_load_in <= ld;
        carry_load_in <= ld;
        acc_load_data_in <= la;
        carry_load_data_in <= la[0];
        wait_phase(2'h1);
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(negedge clk_sys_in) begin
        chk1("zero_we", 1'b0, zero_we_out);
        chk1("dcarry_we", 1'b0, dcarry_we_out);
        if (phase_out === 2'h1) begin
            cur_v = notes.size() > 0;
            if (cur_v) cur = notes.pop_front();
            chk1("freg_re", cur_v & cur.rot, freg_re_out);
            chk1("busy", cur_v & cur.rot, busy_out);
            if (cur_v && cur.rot) begin
                chk8("raddr", {1'b0, cur.addr}, {1'b0, freg_addr_out});
            end
        end
        if (phase_out === 2'h3) begin
            chk1("freg_we", cur_v & cur.rot & cur.d, freg_we_out);
            if (cur_v && cur.rot && cur.d) begin
                chk8("freg_wdata", cur.wdata, freg_wdata_out);
                chk8("waddr", {1'b0, cur.addr}, {1'b0, freg_addr_out});
            end
        end
        if (phase_out === 2'h0 && cur_v) begin
            chk8("acc", cur.acc, acc_out);
            chk1("carry", cur.carry, carry_out);
            cur_v = 1'b0;
        end
    end

    // clock and hang guard; the run needs well under 1000 cycles
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        logic [31:0] s;
        {arst_n_in, acc_load_in, carry_load_in, carry_load_data_in} = '0;
        clk_en_in = 1'b1;
        insn_in = '0;
        freg_rdata_in = '0;
        acc_load_data_in = '0;
        {m_acc, m_carry} = '0;
        seed = 32'h7600;
        repeat (4) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        wait_phase(2'h1);
        // both ops, both destinations, edge bytes and addresses, back to back
        for (int i = 0; i < 16; i++) begin
            run({i[0] ? OPC_ROT_LEFT : OPC_ROT_RIGHT, i[1],
                i[1] ? 7'h7F : 7'h00}, i[2] ? 8'h80 : 8'h01, i[3]);
        end
        // random mix, including words that are not rotates
        for (int i = 0; i < 48; i++) begin
            s = seed;
            seed = lfsr_next(seed);
            run(s[27] ? s[13:0] : {s[26] ? OPC_ROT_LEFT : OPC_ROT_RIGHT,
                s[7:0]}, s[23:16], s[24]);
        end
        run(14'h0000, 8'h00, 1'b0);
        repeat (8) @(posedge clk_sys_in);
        tally_and_finish();
    end
endmodule
